// ==== logic/trl_logger.sv ====
`timescale 1ns/1ns
// What this block does
// - Enabled buffer stores record per encoder trigger.
// - Buffer is 1024 words, 204 records.
// - Encoder trigger is OR of channel triggers.
// - Channel cannot retrigger while status pending.
// - After record, encoder status cleared automatically.
// - Record order: time, ch0, ch1, ch2, port.
// - Time word holds full captured timestamp.
// - Encoder word: direction, seven flags, count.
// - Port word: four bits low, zeros above.
// - Status shows count, empty and full.
// - Init bit one flushes, zero readies.
// - Bit zero rising write advances read entry.
// - Read returns entry; any write advances.
// - Full buffer discards further records.
// - Polarity bits pick rising or falling edge.
// - Enable bits arm per-input event detection.
// - Events set sticky flags; write one clears.
// - Set flag blocks further events on input.
// - Enabled buffer auto-clears input event flags.
// - Port bit reads one when pin low.
// - Every trigger copies counter into capture.
// - Input events join combined trigger output.
// - Encoder status clear pulses reach channels.
module trl_logger #(
    parameter int DEPTH = trl_pkg::DEPTH
) (
    // Clock and reset.
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    // AXI4-Lite write channels.
    input  wire logic [7:0]            s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    // AXI4-Lite read channels.
    input  wire logic [7:0]            s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    // Encoder channels.
    input  wire logic [2:0]            enc_trig_in,
    input  wire trl_pkg::trl_enc_word_t enc_word_in [3],
    input  wire logic [2:0]            enc_sw_clear_in,
    output logic [2:0]                 enc_status_clear,
    // Timestamp counter and digital input pins (pins active low).
    input  wire logic [31:0]           timestamp_counter,
    input  wire logic [3:0]            digital_input_pin_n,
    // Trigger and level outputs.
    output logic                       combined_trigger,
    output logic [31:0]                timestamp_capture_reg,
    output logic                       half_full
);
    localparam int AW = $clog2(DEPTH);
    // Half-full scales with the depth; the default depth gives 512.
    localparam int HALF = DEPTH * trl_pkg::HALF_LEVEL / trl_pkg::DEPTH;

    logic [31:0]   mem [DEPTH];
    logic [AW-1:0] wptr_r, rptr_r;
    logic [AW:0]   count_r;
    logic          enable_r, init_r, adv_bit_r;
    logic [7:0]    evt_ctrl_r;
    logic [3:0]    evt_flag_r;
    logic [3:0]    sync1_r, sync2_r, level_r;
    logic [2:0]    pending_r;
    logic [31:0]   rec_r [trl_pkg::REC_WORDS];
    logic [2:0]    idx_r;
    trl_pkg::trl_state_t state_r;

    // Front-end: two-stage synchroniser, the first stage feeds only the second.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            // Pins idle high, so the stages start there and no false edge follows reset.
            sync1_r <= 4'hf;
            sync2_r <= 4'hf;
            level_r <= 4'hf;
        end else begin
            sync1_r <= digital_input_pin_n;
            sync2_r <= sync1_r;
            level_r <= sync2_r;
        end
    end

    logic [3:0] port_bits;
    assign port_bits = ~sync2_r;

    // Edge events on the pin level, per input.
    logic [3:0] in_event;
    for (genvar i = 0; i < trl_pkg::NUM_IN; i++) begin : g_in
        logic rise, fall;
        assign rise = sync2_r[i] & ~level_r[i];
        assign fall = ~sync2_r[i] & level_r[i];
        assign in_event[i] = evt_ctrl_r[i]
            & (evt_ctrl_r[trl_pkg::POL_LSB+i] ? rise : fall)
            & ~evt_flag_r[i];
    end

    // Encoder triggers are ignored while that channel's status is pending.
    logic [2:0] ch_trig;
    logic       enc_trig;
    assign ch_trig  = enc_trig_in & ~pending_r;
    assign enc_trig = |ch_trig;
    assign combined_trigger = enc_trig | (|in_event);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pending_r <= 3'h0;
        end else begin
            pending_r <= (pending_r & ~(enc_status_clear | enc_sw_clear_in)) | ch_trig;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            timestamp_capture_reg <= 32'h0;
        end else if (combined_trigger) begin
            timestamp_capture_reg <= timestamp_counter;
        end
    end

    // Record writer. Five free words are required up front so a record is
    // never split, which keeps the word order intact for the reader.
    logic free5, start, wr_en, rd_adv, empty, full;
    assign full  = count_r == (AW+1)'(DEPTH);
    assign empty = count_r == '0;
    assign free5 = ((AW+1)'(DEPTH) - count_r) >= (AW+1)'(trl_pkg::REC_WORDS);
    assign start = enable_r & enc_trig & free5 & ~init_r
                   & (state_r == trl_pkg::ST_IDLE);
    assign wr_en = (state_r == trl_pkg::ST_WRITE) & ~init_r;
    assign half_full = count_r >= (AW+1)'(HALF);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r <= trl_pkg::ST_IDLE;
            idx_r   <= 3'h0;
        end else begin
            unique case (state_r)
                trl_pkg::ST_IDLE: begin
                    idx_r <= 3'h0;
                    if (start) begin
                        state_r <= trl_pkg::ST_WRITE;
                    end
                end
                trl_pkg::ST_WRITE: begin
                    idx_r <= idx_r + 3'h1;
                    if (init_r || idx_r == 3'(trl_pkg::REC_WORDS - 1)) begin
                        state_r <= trl_pkg::ST_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            enc_status_clear <= 3'h0;
        end else begin
            enc_status_clear <= {3{wr_en & idx_r == 3'(trl_pkg::REC_WORDS - 1)}};
        end
    end

    // Snapshot all record words at the trigger.
    always_ff @(posedge aclk) begin
        if (start) begin
            rec_r[0] <= timestamp_counter;
            for (int c = 0; c < trl_pkg::NUM_CH; c++) begin
                rec_r[c+1] <= enc_word_in[c];
            end
            rec_r[4] <= {28'h0, port_bits};
        end
    end

    always_ff @(posedge aclk) begin
        if (wr_en) begin
            mem[wptr_r] <= rec_r[idx_r];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || init_r) begin
            wptr_r  <= '0;
            rptr_r  <= '0;
            count_r <= '0;
        end else begin
            // Pointers wrap at the depth, which need not be a power of two.
            if (wr_en) begin
                wptr_r <= (wptr_r == AW'(DEPTH - 1)) ? '0 : wptr_r + AW'(1);
            end
            if (rd_adv && !empty) begin
                rptr_r <= (rptr_r == AW'(DEPTH - 1)) ? '0 : rptr_r + AW'(1);
            end
            count_r <= count_r + (AW+1)'(wr_en) - (AW+1)'(rd_adv && !empty);
        end
    end

    // AXI4-Lite slave. Address and data are held until both are present.
    logic       aw_h_r, w_h_r;
    logic [7:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic       do_wr;
    assign s_axi_awready = ~aw_h_r & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_h_r & ~s_axi_bvalid;
    assign s_axi_arready = ~s_axi_rvalid;
    assign do_wr = aw_h_r & w_h_r & ~s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_h_r       <= 1'b0;
            w_h_r        <= 1'b0;
            awaddr_r     <= 8'h0;
            wdata_r      <= 32'h0;
            wstrb_r      <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= trl_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_h_r   <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_h_r   <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            if (do_wr) begin
                aw_h_r       <= 1'b0;
                w_h_r        <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (awaddr_r > trl_pkg::A_EVT_FLAGS || awaddr_r[1:0] != 2'h0)
                                ? trl_pkg::RESP_SLVERR : trl_pkg::RESP_OKAY;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    logic wr_en_reg, wr_state, wr_read, wr_ctrl, wr_flags;
    assign wr_en_reg = do_wr & awaddr_r == trl_pkg::A_ENABLE & wstrb_r[1];
    assign wr_state  = do_wr & awaddr_r == trl_pkg::A_STATE & wstrb_r[0];
    assign wr_read   = do_wr & awaddr_r == trl_pkg::A_READ;
    assign wr_ctrl   = do_wr & awaddr_r == trl_pkg::A_EVT_CTRL & wstrb_r[0];
    assign wr_flags  = do_wr & awaddr_r == trl_pkg::A_EVT_FLAGS & wstrb_r[0];
    // A zero-then-one on the advance bit and any write to the read port
    // both step the head of the buffer.
    assign rd_adv = wr_read
        | (wr_state & wdata_r[trl_pkg::ADV_BIT] & ~adv_bit_r);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            enable_r   <= 1'b0;
            init_r     <= 1'b0;
            adv_bit_r  <= 1'b0;
            evt_ctrl_r <= 8'h0;
        end else begin
            if (wr_en_reg) begin
                enable_r <= wdata_r[trl_pkg::EN_BIT];
            end
            if (wr_state) begin
                init_r    <= wdata_r[trl_pkg::INIT_BIT];
                adv_bit_r <= wdata_r[trl_pkg::ADV_BIT];
            end
            if (wr_ctrl) begin
                evt_ctrl_r <= wdata_r[7:0];
            end
        end
    end

    // A new event wins over a clear in the same cycle.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            evt_flag_r <= 4'h0;
        end else begin
            evt_flag_r <= (evt_flag_r & ~({4{wr_flags}} & wdata_r[3:0])
                           & ~{4{enable_r}})
                          | in_event;
        end
    end

    // Register reads.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0;
            s_axi_rresp  <= trl_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= trl_pkg::RESP_OKAY;
            s_axi_rdata  <= 32'h0;
            unique case (s_axi_araddr)
                trl_pkg::A_ENABLE:    s_axi_rdata[trl_pkg::EN_BIT] <= enable_r;
                trl_pkg::A_STATE: begin
                    s_axi_rdata[trl_pkg::CNT_LSB +: AW+1] <= count_r;
                    s_axi_rdata[trl_pkg::EMPTY_BIT]       <= empty;
                    s_axi_rdata[trl_pkg::FULL_BIT]        <= full;
                    s_axi_rdata[trl_pkg::INIT_BIT]        <= init_r;
                    s_axi_rdata[trl_pkg::ADV_BIT]         <= adv_bit_r;
                end
                trl_pkg::A_READ:      s_axi_rdata <= empty ? 32'h0 : mem[rptr_r];
                trl_pkg::A_EVT_CTRL:  s_axi_rdata[7:0] <= evt_ctrl_r;
                trl_pkg::A_EVT_FLAGS: s_axi_rdata[3:0] <= evt_flag_r;
                default:              s_axi_rresp <= trl_pkg::RESP_SLVERR;
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Checks on the logger.
    a_full_blocks_start: assert property (@(posedge aclk) disable iff (!aresetn)
        full |-> !start) else $error("record started while full");
    a_record_five_words: assert property (@(posedge aclk) disable iff (!aresetn)
        start ##1 !init_r [*5] |=> !wr_en && state_r == trl_pkg::ST_IDLE)
        else $error("record longer than five words");
    a_write_run: assert property (@(posedge aclk) disable iff (!aresetn)
        start ##1 !init_r [*5] |->
            $past(wr_en, 4) && $past(wr_en, 3) && $past(wr_en, 2) && $past(wr_en) && wr_en)
        else $error("record words not consecutive");
    a_clear_after_rec: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_en && idx_r == 3'h4 |=> enc_status_clear == 3'h7)
        else $error("status not cleared after record");
    a_no_retrigger: assert property (@(posedge aclk) disable iff (!aresetn)
        ch_trig[0] |=> !ch_trig[0]) else $error("channel retriggered");
    a_flag_blocks: assert property (@(posedge aclk) disable iff (!aresetn)
        evt_flag_r[0] |-> !in_event[0]) else $error("event on set flag");
    a_flag_sets: assert property (@(posedge aclk) disable iff (!aresetn)
        in_event[1] |=> evt_flag_r[1]) else $error("event flag not set");
    a_ts_capture: assert property (@(posedge aclk) disable iff (!aresetn)
        combined_trigger |=> timestamp_capture_reg == $past(timestamp_counter))
        else $error("timestamp not captured");
    a_half_full: assert property (@(posedge aclk) disable iff (!aresetn)
        count_r == (AW+1)'(HALF) |-> half_full) else $error("half-full wrong");
    a_init_flush: assert property (@(posedge aclk) disable iff (!aresetn)
        init_r |=> count_r == '0 && !wr_en) else $error("flush failed");
    c_record: cover property (@(posedge aclk) start ##6 enc_status_clear[0]);
    c_full: cover property (@(posedge aclk) full);
    c_event: cover property (@(posedge aclk) in_event[2] && !enable_r);
endmodule

// ==== logic/trl_pkg.sv ====
package trl_pkg;
    localparam int             DEPTH       = 1024;
    localparam int             REC_WORDS   = 5;
    localparam int             NUM_CH      = 3;
    localparam int             NUM_IN      = 4;
    localparam int             HALF_LEVEL  = 512;
    // Byte addresses of the register map.
    localparam logic [7:0]     A_ENABLE    = 8'h00;
    localparam logic [7:0]     A_STATE     = 8'h04;
    localparam logic [7:0]     A_READ      = 8'h08;
    localparam logic [7:0]     A_EVT_CTRL  = 8'h0c;
    localparam logic [7:0]     A_EVT_FLAGS = 8'h10;
    // Field positions.
    localparam int             EN_BIT      = 8;
    localparam int             CNT_LSB     = 10;
    localparam int             EMPTY_BIT   = 9;
    localparam int             FULL_BIT    = 8;
    localparam int             INIT_BIT    = 1;
    localparam int             ADV_BIT     = 0;
    localparam int             POL_LSB     = 4;
    localparam logic [1:0]     RESP_OKAY   = 2'h0;
    localparam logic [1:0]     RESP_SLVERR = 2'h2;

    // Encoder channel view: last direction, latched events, output-latch count.
    typedef struct packed {
        logic        last_dir;
        logic [6:0]  ev_flags;
        logic [23:0] count;
    } trl_enc_word_t;

    typedef enum logic [1:0] {ST_IDLE, ST_WRITE} trl_state_t;
endpackage

// ==== test/trl_enc_model.sv ====
`timescale 1ns/1ns
module trl_enc_model (
    // Clock, reset and bench command.
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [2:0]        fire,
    // Channel side of the logger.
    output logic [2:0]             enc_trig_in,
    output trl_pkg::trl_enc_word_t enc_word_in [3],
    output logic [31:0]            timestamp_counter,
    output logic [31:0]            last_ts
);
    // Each channel drives its own line; merging them is the logger's job.
    assign enc_trig_in = fire;
    always_comb begin
        for (int c = 0; c < 3; c++) begin
            enc_word_in[c] = {c == 1, 7'h55 ^ 7'(c), 8'(c), 16'h3c5a};
        end
    end
    // Starts high so that the upper half of the time word is never zero.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            timestamp_counter <= 32'hfff0_0000;
        end else begin
            timestamp_counter <= timestamp_counter + 32'h1;
        end
    end
    // Counter value that the logger should capture at a trigger edge.
    always_ff @(posedge aclk) begin
        if (|fire) begin
            last_ts <= timestamp_counter;
        end
    end
endmodule

// ==== test/trl_logger_tb_top.sv ====
`timescale 1ns/1ns
module trl_logger_tb_top;
    // Bus, pin and partner signals.
    logic                   aclk = 1'b0;
    logic                   aresetn = 1'b0;
    logic [7:0]             awaddr = 8'h00, araddr = 8'h00;
    logic                   awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic                   arvalid = 1'b0, rready = 1'b0;
    logic [31:0]            wdata = 32'h0;
    logic                   awready, wready, bvalid, arready, rvalid, ctrig, hfull;
    logic [1:0]             bresp, rresp, rsp;
    logic [31:0]            rdata, ts_cap, ts_cnt, last_ts, got;
    logic [2:0]             fire = 3'h0, swclr = 3'h0, trig, sclr;
    logic [3:0]             pin_n = 4'hf;
    trl_pkg::trl_enc_word_t ew [3];
    int                     n_mismatch = 0, check_count = 0, n_clear = 0;
    logic [31:0]            ts_q [$];

    always #25 aclk = ~aclk;

    // Status-clear pulses are counted at the falling edge, where each one stands settled.
    always @(negedge aclk) begin
        if (sclr == 3'h7) begin
            n_clear++;
        end
    end

    trl_logger #(.DEPTH(20)) trl_logger_i (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .enc_trig_in(trig), .enc_word_in(ew), .enc_sw_clear_in(swclr),
        .enc_status_clear(sclr), .timestamp_counter(ts_cnt),
        .digital_input_pin_n(pin_n), .combined_trigger(ctrig),
        .timestamp_capture_reg(ts_cap), .half_full(hfull)
    );
    trl_enc_model trl_enc_model_i (
        .aclk(aclk), .aresetn(aresetn), .fire(fire), .enc_trig_in(trig),
        .enc_word_in(ew), .timestamp_counter(ts_cnt), .last_ts(last_ts)
    );

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Handshakes are judged at the falling edge, which shows what the next rising edge takes.
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int   n;
        logic ta, tw, done;
        n = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(negedge aclk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            done = bvalid;
            r = bresp;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            n++;
        end while (!done && n < 50);
        bready <= 1'b0;
        if (!done) begin
            n_mismatch++;
            give_verdict();
        end
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int   n;
        logic ta, done;
        n = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(negedge aclk);
            ta = arvalid && arready;
            done = rvalid;
            d = rdata;
            r = rresp;
            @(posedge aclk);
            if (ta) arvalid <= 1'b0;
            n++;
        end while (!done && n < 50);
        rready <= 1'b0;
        if (!done) begin
            n_mismatch++;
            give_verdict();
        end
    endtask

    function automatic logic [31:0] exp_enc(input int c);
        return {c == 1, 7'h55 ^ 7'(c), 8'(c), 16'h3c5a};
    endfunction

    // Only count, empty and full are compared; the command bits are masked off and never checked.
    task automatic chk_state(input int c, input logic f);
        rd(trl_pkg::A_STATE, got, rsp);
        check("state", got & 32'h001fff00, (32'(c) << 10) | {22'h0, c == 0, f, 8'h00});
    endtask

    task automatic fire_ch(input int c);
        @(posedge aclk);
        fire <= 3'(1 << c);
        @(negedge aclk);
        check("combined trigger", {31'h0, ctrig}, 32'h1);
        @(posedge aclk);
        fire <= 3'h0;
        repeat (10) @(posedge aclk);
        ts_q.push_back(last_ts);
    endtask

    task automatic enable_buf;
        wr(trl_pkg::A_ENABLE, 32'h100, rsp);
        swclr <= 3'h7;
        @(posedge aclk);
        swclr <= 3'h0;
    endtask

    task automatic drain(input logic [31:0] ts, input logic [3:0] pins);
        for (int i = 0; i < 5; i++) begin
            rd(trl_pkg::A_READ, got, rsp);
            if (i == 0) check("time word", got, ts);
            else if (i < 4) check("encoder word", got, exp_enc(i - 1));
            else check("port word", got, {28'h0, ~pins});
            wr(trl_pkg::A_READ, 32'h5a5a_0000, rsp);
        end
    endtask

    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        chk_state(0, 1'b0);
        rd(8'h14, got, rsp);
        check("unmapped read", {30'h0, rsp}, {30'h0, trl_pkg::RESP_SLVERR});
        wr(8'h14, 32'hffff_ffff, rsp);
        check("unmapped write", {30'h0, rsp}, {30'h0, trl_pkg::RESP_SLVERR});
        // Set early so the port bits have passed both synchroniser stages by the trigger.
        pin_n <= 4'ha;
        enable_buf();
        rd(trl_pkg::A_ENABLE, got, rsp);
        check("enable", got, 32'h100);
        fire_ch(1);
        chk_state(5, 1'b0);
        check("status clears", n_clear, 32'h1);
        check("capture", ts_cap, ts_q[0]);
        check("half full", {31'h0, hfull}, 32'h0);
        drain(ts_q[0], 4'ha);
        chk_state(0, 1'b0);
        wr(trl_pkg::A_ENABLE, 32'h0, rsp);
        fire_ch(0);
        chk_state(0, 1'b0);
        check("no clear when off", n_clear, 32'h1);
        enable_buf();
        for (int i = 0; i < 5; i++) fire_ch(i % 3);
        chk_state(20, 1'b1);
        check("half full set", {31'h0, hfull}, 32'h1);
        check("clears per record", n_clear, 32'h5);
        wr(trl_pkg::A_ENABLE, 32'h0, rsp);
        rd(trl_pkg::A_READ, got, rsp);
        check("oldest word", got, ts_q[2]);
        wr(trl_pkg::A_STATE, 32'h0, rsp);
        wr(trl_pkg::A_STATE, 32'h1, rsp);
        chk_state(19, 1'b0);
        wr(trl_pkg::A_STATE, 32'h2, rsp);
        chk_state(0, 1'b0);
        wr(trl_pkg::A_STATE, 32'h0, rsp);
        enable_buf();
        fire_ch(2);
        chk_state(5, 1'b0);
        wr(trl_pkg::A_ENABLE, 32'h0, rsp);
        pin_n <= 4'hf;
        wr(trl_pkg::A_EVT_CTRL, 32'h13, rsp);
        wr(trl_pkg::A_EVT_FLAGS, 32'hf, rsp);
        rd(trl_pkg::A_EVT_CTRL, got, rsp);
        check("event control", got, 32'h13);
        // Input 2 toggles while unarmed; input 0 falls first, which is the wrong edge.
        pin_n <= 4'h9;
        repeat (6) @(posedge aclk);
        pin_n <= 4'h8;
        repeat (6) @(posedge aclk);
        pin_n <= 4'h9;
        repeat (6) @(posedge aclk);
        rd(trl_pkg::A_EVT_FLAGS, got, rsp);
        check("event flags", got, 32'h3);
        // A second rise on input 0 with its flag still set must not capture again.
        got = ts_cap;
        pin_n <= 4'h8;
        repeat (6) @(posedge aclk);
        pin_n <= 4'h9;
        repeat (6) @(posedge aclk);
        check("blocked event", ts_cap, got);
        wr(trl_pkg::A_EVT_FLAGS, 32'h0, rsp);
        rd(trl_pkg::A_EVT_FLAGS, got, rsp);
        check("flags after zero", got, 32'h3);
        wr(trl_pkg::A_EVT_FLAGS, 32'h1, rsp);
        rd(trl_pkg::A_EVT_FLAGS, got, rsp);
        check("flags after one", got, 32'h2);
        enable_buf();
        rd(trl_pkg::A_EVT_FLAGS, got, rsp);
        check("flags auto clear", got, 32'h0);
        give_verdict();
    end
endmodule
